// [src/ipc_pkg.sv]
// Purpose: Constants, types and helpers for the input path configuration block
// Assumes: 50 MHz clk; register port is a simple synchronous word port
// Notes: Bit clock half periods are whole clk cycles, rounded down
// Operation
// - Scope bit 0 gives global rate everywhere
// - Scope bit 1 uses per-channel rates
// - Path one mode bit selects analog or PDM
// - Path two is PDM only, own pins
// - Path one source field selects pin choice
// - Per-channel filter enable, shared cut-off select
// - Analog preamp gain 0 to 31 dB
// - Device generates PDM bit clock in digital
// - Oversample field selects bit clock frequency
// - Analog oversample code selects mid-power mode
// - Mid-power forces at least 6 dB gain
// - Low-power bit selects low-power analog operation
// - Fastest bit clock selects high-performance PDM
// - Reference field selects pin logic rail
// - Sample left at high end, right low
// - Enable bits three to zero ordered
package ipc_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int RATE_W = 5;
    localparam int HALF_W = 7;
    // Register byte addresses
    localparam logic [15:0] ADDR_INPUT_CONTROL = 16'h4000;
    localparam logic [15:0] ADDR_INPUT_STATUS = 16'h4004;
    localparam logic [15:0] ADDR_RATE_SCOPE = 16'h4008;
    localparam logic [15:0] ADDR_PATH_ONE = 16'h4020;
    localparam logic [15:0] ADDR_P1_LEFT = 16'h4024;
    localparam logic [15:0] ADDR_P1_LEFT_GAIN = 16'h4028;
    localparam logic [15:0] ADDR_P1_RIGHT = 16'h4044;
    localparam logic [15:0] ADDR_P1_RIGHT_GAIN = 16'h4048;
    localparam logic [15:0] ADDR_PATH_TWO = 16'h4060;
    localparam logic [15:0] ADDR_P2_LEFT = 16'h4064;
    localparam logic [15:0] ADDR_P2_RIGHT = 16'h4084;
    localparam logic [15:0] ADDR_HPF_CUT = 16'h4244;
    // Field positions
    localparam int EN_P2L = 3;
    localparam int EN_P2R = 2;
    localparam int EN_P1L = 1;
    localparam int EN_P1R = 0;
    localparam int SCOPE_BIT = 10;
    localparam int OSR_LSB = 16;
    localparam int REF_LSB = 8;
    localparam int KEEP_BIT = 5;
    localparam int MODE_BIT = 0;
    localparam int SRC_LSB = 28;
    localparam int HPF_BIT = 2;
    localparam int LP_BIT = 0;
    localparam int GAIN_LSB = 1;
    // Reset values and codes
    localparam logic [2:0] OSR_RESET = 3'h5;
    localparam logic [2:0] OSR_MID = 3'h2;
    localparam logic [2:0] OSR_HIGH_PDM = 3'h6;
    localparam logic [2:0] CUT_RESET = 3'h2;
    localparam logic [6:0] GAIN_RESET = 7'h40;
    localparam logic [6:0] GAIN_ZERO = 7'h40;
    localparam logic [6:0] GAIN_TOP = 7'h5f;
    localparam logic [4:0] GAIN_MAX_DB = 5'h1f;
    localparam logic [4:0] GAIN_MID_MIN_DB = 5'h06;
    localparam logic [1:0] REF_RESET = 2'h0;
    localparam logic [1:0] SRC_RESET = 2'h0;
    // Bit clock frequencies in Hz per oversample code
    localparam int F0 = 384000;
    localparam int F1 = 768000;
    localparam int F2 = 1536000;
    localparam int F3 = 2048000;
    localparam int F4 = 2457600;
    localparam int F5 = 3072000;
    localparam int F6 = 6144000;

    typedef struct packed {
        logic left;
        logic right;
        logic valid;
    } ipc_sample_s;

    // Half period of the bit clock in clk cycles; zero stops the clock
    function automatic logic [HALF_W-1:0] ipc_half_cycles(input logic [2:0] osr);
        int f;
        f = 0;
        case (osr)
            3'h0: f = F0;
            3'h1: f = F1;
            3'h2: f = F2;
            3'h3: f = F3;
            3'h4: f = F4;
            3'h5: f = F5;
            3'h6: f = F6;
            default: f = 0;
        endcase
        if (f == 0) begin
            return '0;
        end
        return HALF_W'(CLK_HZ / (2 * f));
    endfunction : ipc_half_cycles

    // Preamp code to dB, clamped to the legal span
    function automatic logic [4:0] ipc_gain_db(input logic [6:0] code, input logic mid);
        logic [4:0] db;
        db = '0;
        if (code >= GAIN_TOP) begin
            db = GAIN_MAX_DB;
        end else if (code > GAIN_ZERO) begin
            db = 5'(code - GAIN_ZERO);
        end
        if (mid && db < GAIN_MID_MIN_DB) begin
            db = GAIN_MID_MIN_DB;
        end
        return db;
    endfunction : ipc_gain_db
endpackage : ipc_pkg

// [src/ipc_pdm_port.sv]
// Purpose: One PDM port: bit clock generator and stereo bit capture
// Assumes: Data pin is asynchronous to clk
// Notes: Clock is held low while disabled
`timescale 1ns/10ps
module ipc_pdm_port (
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire logic run,
    input wire logic [ipc_pkg::HALF_W-1:0] half_count,
    // Pins
    input wire logic bitstream,
    output logic bit_clock,
    // Captured bits
    output ipc_pkg::ipc_sample_s sample
);
    import ipc_pkg::*;

    logic sync1_r;
    logic sync2_r;
    logic [HALF_W-1:0] cnt_r;
    logic left_r;
    logic phase_end;

    // Two-stage synchroniser for the data pin
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= bitstream;
            sync2_r <= sync1_r;
        end
    end

    assign phase_end = run && (half_count != '0) && (cnt_r >= half_count - HALF_W'(1));

    // Divider; a reserved rate code stops the clock rather than guess
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= '0;
            bit_clock <= 1'b0;
        end else if (!run || half_count == '0) begin
            cnt_r <= '0;
            bit_clock <= 1'b0;
        end else if (phase_end) begin
            cnt_r <= '0;
            bit_clock <= ~bit_clock;
        end else begin
            cnt_r <= cnt_r + HALF_W'(1);
        end
    end

    // Capture at each phase end; pair is complete after the low phase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            left_r <= 1'b0;
            sample <= '0;
        end else begin
            sample.valid <= 1'b0;
            if (phase_end && bit_clock) begin
                left_r <= sync2_r;
            end else if (phase_end && !bit_clock) begin
                sample.left <= left_r;
                sample.right <= sync2_r;
                sample.valid <= 1'b1;
            end
        end
    end
endmodule : ipc_pdm_port

// [src/ipc_input_path_config.sv]
// Purpose: Register file and decoded controls for two stereo input paths
// Assumes: Software keeps enables clear while changing mode or gain
// Notes: Outputs are registered; decoded controls lag a write by one cycle
`timescale 1ns/10ps
module ipc_input_path_config (
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Sample rates from the rate block
    input wire logic [ipc_pkg::RATE_W-1:0] global_rate,
    input wire logic [4*ipc_pkg::RATE_W-1:0] per_channel_rate,
    output logic [4*ipc_pkg::RATE_W-1:0] channel_rate,
    // PDM pins and captured samples
    input wire logic path_one_bitstream,
    output logic path_one_bit_clock,
    input wire logic path_two_bitstream,
    output logic path_two_bit_clock,
    output ipc_pkg::ipc_sample_s path_one_sample,
    output ipc_pkg::ipc_sample_s path_two_sample,
    // Front end, PDM and filter controls
    output logic [3:0] channel_enable,
    output logic path_one_digital_select,
    output logic [1:0] path_one_left_source,
    output logic [1:0] path_one_right_source,
    output logic [4:0] left_preamp_gain,
    output logic [4:0] right_preamp_gain,
    output logic mid_power,
    output logic [1:0] low_power_select,
    output logic [1:0] high_perf_pdm,
    output logic [1:0] path_one_level_ref,
    output logic [1:0] path_two_level_ref,
    output logic [3:0] highpass_enable,
    output logic [2:0] highpass_cutoff_select
);
    import ipc_pkg::*;

    logic [3:0] en_r;
    logic scope_r;
    logic [2:0] osr1_r;
    logic [2:0] osr2_r;
    logic [1:0] ref1_r;
    logic [1:0] ref2_r;
    logic keep1_r;
    logic keep2_r;
    logic mode_r;
    logic [1:0] src_l_r;
    logic [1:0] src_r_r;
    logic [3:0] hpf_r;
    logic [1:0] lp_r;
    logic [6:0] gain_l_r;
    logic [6:0] gain_r_r;
    logic [2:0] cut_r;
    logic mid_nxt;
    logic run1;
    logic run2;
    logic [31:0] rd_nxt;
    ipc_sample_s s1;
    ipc_sample_s s2;

    // Enables and rate scope
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_r <= '0;
            scope_r <= 1'b1;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_INPUT_CONTROL) begin
                en_r <= reg_wdata[EN_P2L:EN_P1R];
            end
            if (reg_addr == ADDR_RATE_SCOPE) begin
                scope_r <= reg_wdata[SCOPE_BIT];
            end
        end
    end

    // Path level controls; bit 5 is stored and read back as written
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            osr1_r <= OSR_RESET;
            osr2_r <= OSR_RESET;
            ref1_r <= REF_RESET;
            ref2_r <= REF_RESET;
            keep1_r <= 1'b1;
            keep2_r <= 1'b1;
            mode_r <= 1'b0;
        end else if (reg_wr && reg_addr == ADDR_PATH_ONE) begin
            osr1_r <= reg_wdata[OSR_LSB+2:OSR_LSB];
            ref1_r <= reg_wdata[REF_LSB+1:REF_LSB];
            keep1_r <= reg_wdata[KEEP_BIT];
            mode_r <= reg_wdata[MODE_BIT];
        end else if (reg_wr && reg_addr == ADDR_PATH_TWO) begin
            osr2_r <= reg_wdata[OSR_LSB+2:OSR_LSB];
            ref2_r <= reg_wdata[REF_LSB+1:REF_LSB];
            keep2_r <= reg_wdata[KEEP_BIT];
        end
    end

    // Channel controls
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            src_l_r <= SRC_RESET;
            src_r_r <= SRC_RESET;
            hpf_r <= '0;
            lp_r <= '0;
            gain_l_r <= GAIN_RESET;
            gain_r_r <= GAIN_RESET;
            cut_r <= CUT_RESET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                ADDR_P1_LEFT: begin
                    src_l_r <= reg_wdata[SRC_LSB+1:SRC_LSB];
                    hpf_r[EN_P1L] <= reg_wdata[HPF_BIT];
                    lp_r[1] <= reg_wdata[LP_BIT];
                end
                ADDR_P1_RIGHT: begin
                    src_r_r <= reg_wdata[SRC_LSB+1:SRC_LSB];
                    hpf_r[EN_P1R] <= reg_wdata[HPF_BIT];
                    lp_r[0] <= reg_wdata[LP_BIT];
                end
                ADDR_P2_LEFT: hpf_r[EN_P2L] <= reg_wdata[HPF_BIT];
                ADDR_P2_RIGHT: hpf_r[EN_P2R] <= reg_wdata[HPF_BIT];
                ADDR_P1_LEFT_GAIN: gain_l_r <= reg_wdata[GAIN_LSB+6:GAIN_LSB];
                ADDR_P1_RIGHT_GAIN: gain_r_r <= reg_wdata[GAIN_LSB+6:GAIN_LSB];
                ADDR_HPF_CUT: cut_r <= reg_wdata[2:0];
                default: begin
                end
            endcase
        end
    end

    // Read data mux; unmapped addresses read as zero
    always_comb begin
        rd_nxt = '0;
        unique case (reg_addr)
            ADDR_INPUT_CONTROL: rd_nxt[EN_P2L:EN_P1R] = en_r;
            ADDR_INPUT_STATUS: rd_nxt[EN_P2L:EN_P1R] = channel_enable;
            ADDR_RATE_SCOPE: rd_nxt[SCOPE_BIT] = scope_r;
            ADDR_PATH_ONE: begin
                rd_nxt[OSR_LSB+2:OSR_LSB] = osr1_r;
                rd_nxt[REF_LSB+1:REF_LSB] = ref1_r;
                rd_nxt[KEEP_BIT] = keep1_r;
                rd_nxt[MODE_BIT] = mode_r;
            end
            ADDR_PATH_TWO: begin
                rd_nxt[OSR_LSB+2:OSR_LSB] = osr2_r;
                rd_nxt[REF_LSB+1:REF_LSB] = ref2_r;
                rd_nxt[KEEP_BIT] = keep2_r;
            end
            ADDR_P1_LEFT: begin
                rd_nxt[SRC_LSB+1:SRC_LSB] = src_l_r;
                rd_nxt[HPF_BIT] = hpf_r[EN_P1L];
                rd_nxt[LP_BIT] = lp_r[1];
            end
            ADDR_P1_RIGHT: begin
                rd_nxt[SRC_LSB+1:SRC_LSB] = src_r_r;
                rd_nxt[HPF_BIT] = hpf_r[EN_P1R];
                rd_nxt[LP_BIT] = lp_r[0];
            end
            ADDR_P2_LEFT: rd_nxt[HPF_BIT] = hpf_r[EN_P2L];
            ADDR_P2_RIGHT: rd_nxt[HPF_BIT] = hpf_r[EN_P2R];
            ADDR_P1_LEFT_GAIN: rd_nxt[GAIN_LSB+6:GAIN_LSB] = gain_l_r;
            ADDR_P1_RIGHT_GAIN: rd_nxt[GAIN_LSB+6:GAIN_LSB] = gain_r_r;
            ADDR_HPF_CUT: rd_nxt[2:0] = cut_r;
            default: rd_nxt = '0;
        endcase
    end

    // Read answer one cycle after the request
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            reg_rdata <= reg_rd ? rd_nxt : '0;
        end
    end

    assign mid_nxt = !mode_r && (osr1_r == OSR_MID);
    assign run1 = mode_r && (en_r[EN_P1L] || en_r[EN_P1R]);
    assign run2 = en_r[EN_P2L] || en_r[EN_P2R];

    // Decoded controls, registered so every output comes from a flop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            channel_enable <= '0;
            path_one_digital_select <= 1'b0;
            path_one_left_source <= SRC_RESET;
            path_one_right_source <= SRC_RESET;
            left_preamp_gain <= '0;
            right_preamp_gain <= '0;
            mid_power <= 1'b0;
            low_power_select <= '0;
            high_perf_pdm <= '0;
            path_one_level_ref <= REF_RESET;
            path_two_level_ref <= REF_RESET;
            highpass_enable <= '0;
            highpass_cutoff_select <= CUT_RESET;
        end else begin
            channel_enable <= en_r;
            path_one_digital_select <= mode_r;
            path_one_left_source <= src_l_r;
            // The restriction when path two runs is software's duty; not policed
            path_one_right_source <= src_r_r;
            left_preamp_gain <= ipc_gain_db(gain_l_r, mid_nxt);
            right_preamp_gain <= ipc_gain_db(gain_r_r, mid_nxt);
            mid_power <= mid_nxt;
            low_power_select <= mode_r ? 2'h0 : lp_r;
            high_perf_pdm[0] <= mode_r && (osr1_r == OSR_HIGH_PDM);
            high_perf_pdm[1] <= (osr2_r == OSR_HIGH_PDM);
            path_one_level_ref <= ref1_r;
            path_two_level_ref <= ref2_r;
            highpass_enable <= hpf_r;
            highpass_cutoff_select <= cut_r;
        end
    end

    // Per-channel sample rate, global or individual
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            channel_rate <= '0;
        end else if (scope_r) begin
            channel_rate <= per_channel_rate;
        end else begin
            channel_rate <= {4{global_rate}};
        end
    end

    ipc_pdm_port u_port_one (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(run1),
        .half_count(ipc_half_cycles(osr1_r)),
        .bitstream(path_one_bitstream),
        .bit_clock(path_one_bit_clock),
        .sample(s1)
    );

    ipc_pdm_port u_port_two (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(run2),
        .half_count(ipc_half_cycles(osr2_r)),
        .bitstream(path_two_bitstream),
        .bit_clock(path_two_bit_clock),
        .sample(s2)
    );

    assign path_one_sample = s1;
    assign path_two_sample = s2;
endmodule : ipc_input_path_config

// [testbench/ipc_input_path_config_chk.sv]
// Purpose: Port assertions for ipc_input_path_config
// Assumes: One clk domain, sys_rst active high
// Notes: Sees only top-level ports
`timescale 1ns/10ps
module ipc_input_path_config_chk
    import ipc_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    // PDM side
    input wire logic path_one_bit_clock,
    input wire logic path_two_bit_clock,
    input wire ipc_pkg::ipc_sample_s path_one_sample,
    // Controls
    input wire logic [3:0] channel_enable,
    input wire logic path_one_digital_select,
    input wire logic [4:0] left_preamp_gain,
    input wire logic [4:0] right_preamp_gain,
    input wire logic mid_power,
    input wire logic [1:0] low_power_select,
    input wire logic [1:0] high_perf_pdm
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Shortest legal half period is four clk cycles
    sequence s_two_high;
        path_two_bit_clock[*4];
    endsequence
    sequence s_one_idle;
        (channel_enable[1:0] == 2'h0 || !path_one_digital_select)[*3];
    endsequence
    sequence s_two_idle;
        (channel_enable[3:2] == 2'h0)[*3];
    endsequence

    a_rd_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_rdata_idle: assert property (!reg_rvalid |-> reg_rdata == 32'h0)
        else $error("read data without valid");
    a_two_half: assert property ($rose(path_two_bit_clock) |-> s_two_high)
        else $error("bit clock high phase too short");
    a_one_idle: assert property (s_one_idle |-> !path_one_bit_clock)
        else $error("path one clock runs while idle");
    a_two_idle: assert property (s_two_idle |-> !path_two_bit_clock)
        else $error("path two clock runs while idle");
    a_mid_gain: assert property (mid_power |-> left_preamp_gain >= GAIN_MID_MIN_DB
        && right_preamp_gain >= GAIN_MID_MIN_DB)
        else $error("gain below mid-power floor");
    a_mid_analog: assert property (mid_power |-> !path_one_digital_select)
        else $error("mid power in digital mode");
    a_lp_digital: assert property (path_one_digital_select |-> low_power_select == 2'h0)
        else $error("low power in digital mode");
    a_hp_mode: assert property (high_perf_pdm[0] |-> path_one_digital_select)
        else $error("high performance PDM in analog mode");
    a_valid_pulse: assert property (path_one_sample.valid |->
        path_one_bit_clock ##1 !path_one_sample.valid)
        else $error("sample valid misplaced");
endmodule : ipc_input_path_config_chk

bind ipc_input_path_config ipc_input_path_config_chk u_chk (
    .clk(clk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .path_one_bit_clock(path_one_bit_clock),
    .path_two_bit_clock(path_two_bit_clock), .path_one_sample(path_one_sample),
    .channel_enable(channel_enable), .path_one_digital_select(path_one_digital_select),
    .left_preamp_gain(left_preamp_gain), .right_preamp_gain(right_preamp_gain),
    .mid_power(mid_power), .low_power_select(low_power_select),
    .high_perf_pdm(high_perf_pdm));

// [testbench/ipc_mic_pair.sv]
// Purpose: Behavioural pair of PDM microphones on one data pin
// Assumes: Bit clock comes from the device
// Notes: Pin falls to the pull-down when the clock stops
`timescale 1ns/10ps
module ipc_mic_pair #(
    parameter int DLY = 5
) (
    // Link
    input wire logic bit_clock,
    output logic data,
    // Pattern
    input wire logic left_bit,
    input wire logic right_bit
);
    realtime last;
    initial begin
        data = 1'b0;
        last = 0;
    end
    // Left mic talks in the high phase, clocked by the device
    always @(posedge bit_clock) begin
        last = $realtime;
        data <= #DLY left_bit;
    end
    // Right mic talks in the low phase
    always @(negedge bit_clock) begin
        last = $realtime;
        data <= #DLY right_bit;
    end
    // Both tristate once the clock stops, so the pull-down wins
    always begin
        #100;
        if ($realtime - last > 3000) begin
            data = 1'b0;
        end
    end
endmodule : ipc_mic_pair

// [testbench/ipc_input_path_config_tb.sv]
// Purpose: Self-checking bench for ipc_input_path_config
// Assumes: 50 MHz clk, a mic pair on each PDM port
// Notes: Rows cover register readback; hand tests follow
`timescale 1ns/10ps
module ipc_input_path_config_tb;
    import ipc_pkg::*;
    typedef struct packed {
        logic [15:0] a;
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] e;
    } ipc_row_s;
    logic clk, sys_rst, reg_wr, reg_rd, reg_rvalid;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [4:0] global_rate, left_preamp_gain, right_preamp_gain;
    logic [19:0] per_channel_rate, channel_rate;
    logic path_one_bitstream, path_two_bitstream, path_one_bit_clock, path_two_bit_clock;
    logic m1l, m1r, m2l, m2r, path_one_digital_select, mid_power;
    ipc_sample_s path_one_sample, path_two_sample;
    logic [3:0] channel_enable, highpass_enable;
    logic [1:0] path_one_left_source, low_power_select, high_perf_pdm, path_one_level_ref;
    logic [1:0] path_one_right_source, path_two_level_ref;
    logic [2:0] highpass_cutoff_select;
    int errors, cmp_count;
    ipc_row_s rows [6] = '{'{16'h4000, 32'h8, 32'hf, 32'h8},
        '{16'h4004, 32'hf, 32'hf, 32'h8},
        '{16'h4024, 32'h3000_0005, 32'h3000_0005, 32'h3000_0005},
        '{16'h4064, 32'h4, 32'h4, 32'h4}, '{16'h4244, 32'h4, 32'h7, 32'h4},
        '{16'h4100, 32'hffff_ffff, 32'hffff_ffff, 32'h0}};
    logic [7:0] hv [7] = '{8'h41, 8'h20, 8'h10, 8'h0c, 8'h0a, 8'h08, 8'h04};
    logic [6:0] gc [3] = '{7'h40, 7'h41, 7'h5f};
    logic [4:0] gd [3] = '{5'h00, 5'h01, 5'h1f};

    ipc_input_path_config u_dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .global_rate(global_rate),
        .per_channel_rate(per_channel_rate), .channel_rate(channel_rate),
        .path_one_bitstream(path_one_bitstream), .path_one_bit_clock(path_one_bit_clock),
        .path_two_bitstream(path_two_bitstream), .path_two_bit_clock(path_two_bit_clock),
        .path_one_sample(path_one_sample), .path_two_sample(path_two_sample),
        .channel_enable(channel_enable), .path_one_digital_select(path_one_digital_select),
        .path_one_left_source(path_one_left_source),
        .path_one_right_source(path_one_right_source),
        .left_preamp_gain(left_preamp_gain), .right_preamp_gain(right_preamp_gain),
        .mid_power(mid_power),
        .low_power_select(low_power_select), .high_perf_pdm(high_perf_pdm),
        .path_one_level_ref(path_one_level_ref), .path_two_level_ref(path_two_level_ref),
        .highpass_enable(highpass_enable), .highpass_cutoff_select(highpass_cutoff_select));
    ipc_mic_pair u_mic1 (.bit_clock(path_one_bit_clock), .data(path_one_bitstream),
        .left_bit(m1l), .right_bit(m1r));
    ipc_mic_pair u_mic2 (.bit_clock(path_two_bit_clock), .data(path_two_bitstream),
        .left_bit(m2l), .right_bit(m2r));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task stop_test;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    // One-cycle write strobe; decoded outputs settle before return
    task wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : wr

    task rd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        chk("rvalid", 32'h1, 32'(reg_rvalid));
        chk("rdata", e, reg_rdata & m);
    endtask : rd

    // Bounded wait for a level on the path two clock
    task wl(input logic v);
        int n;
        n = 0;
        while (path_two_bit_clock !== v && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 400) begin
            chk("clock wait", 32'(v), 32'(~v));
            stop_test;
        end
    endtask : wl

    // Skip the phase in flight, then count one whole high phase
    task half(input logic [7:0] e);
        int n;
        wl(1'b1);
        wl(1'b0);
        wl(1'b1);
        n = 0;
        while (path_two_bit_clock === 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("half period", 32'(e), 32'(n));
    endtask : half

    // Second pair after a pattern change carries the new bits
    task wv(input logic one, input logic l, input logic r);
        int n;
        int k;
        ipc_sample_s s;
        k = 0;
        s = '0;
        for (n = 0; n < 1200 && k < 2; n++) begin
            @(posedge clk);
            #1;
            s = one ? path_one_sample : path_two_sample;
            if (s.valid === 1'b1) begin
                k++;
            end
        end
        chk("sample pair", 32'({l, r, 1'b1}), 32'(s));
    endtask : wv

    initial begin
        errors = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0;
        reg_wdata = 32'h0;
        global_rate = 5'h03;
        per_channel_rate = 20'h12345;
        {m1l, m1r, m2l, m2r} = 4'h0;
        repeat (16) @(posedge clk);
        #1;
        chk("cut in reset", 32'h2, 32'(highpass_cutoff_select));
        sys_rst = 1'b0;
        rd(16'h4020, 32'hffff_ffff, 32'h0005_0020);
        rd(16'h4008, 32'h400, 32'h400);
        rd(16'h4028, 32'hfe, 32'h80);
        rd(16'h4024, 32'h3000_0000, 32'h0);
        chk("rate scoped", 32'(per_channel_rate), 32'(channel_rate));
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].m, rows[i].e);
        end
        chk("enables", 32'h8, 32'(channel_enable));
        chk("source", 32'h3, 32'(path_one_left_source));
        chk("low power", 32'h2, 32'(low_power_select));
        chk("hpf", 32'ha, 32'(highpass_enable));
        chk("cut", 32'h4, 32'(highpass_cutoff_select));
        wr(16'h4000, 32'h0);
        wr(16'h4008, 32'h0);
        chk("rate global", 32'({4{global_rate}}), 32'(channel_rate));
        for (int i = 0; i < 3; i++) begin
            wr(16'h4028, {24'h0, gc[i], 1'b0});
            chk("gain", 32'(gd[i]), 32'(left_preamp_gain));
        end
        wr(16'h4020, 32'h0002_0020);
        chk("mid", 32'h1, 32'(mid_power));
        chk("mid gain r", 32'h6, 32'(right_preamp_gain));
        wr(16'h4028, {24'h0, 7'h41, 1'b0});
        chk("mid gain", 32'h6, 32'(left_preamp_gain));
        wr(16'h4020, 32'h0005_0020);
        chk("normal", 32'h0, 32'(mid_power));
        wr(16'h4020, 32'h0006_0121);
        chk("digital", 32'h1, 32'(path_one_digital_select));
        chk("hp one", 32'h1, 32'(high_perf_pdm[0]));
        chk("ref", 32'h1, 32'(path_one_level_ref));
        chk("lp digital", 32'h0, 32'(low_power_select));
        m1l = 1'b1;
        wr(16'h4000, 32'h3);
        wv(1'b1, 1'b1, 1'b0);
        {m1l, m1r} = 2'b01;
        wv(1'b1, 1'b0, 1'b1);
        wr(16'h4000, 32'h0);
        wr(16'h4020, 32'h0005_0020);
        wr(16'h4044, 32'h2000_0000);
        chk("right source", 32'h2, 32'(path_one_right_source));
        m2r = 1'b1;
        wr(16'h4000, 32'hc);
        wv(1'b0, 1'b0, 1'b1);
        for (int i = 0; i < 7; i++) begin
            wr(16'h4060, {13'h0, 3'(i), 16'h0020});
            half(hv[i]);
            chk("hp pdm", 32'(i == 6), 32'(high_perf_pdm[1]));
        end
        wr(16'h4060, 32'h0007_0120);
        repeat (150) @(posedge clk);
        #1;
        chk("reserved osr", 32'h0, 32'(path_two_bit_clock));
        chk("ref two", 32'h1, 32'(path_two_level_ref));
        stop_test;
    end
endmodule : ipc_input_path_config_tb
